// [wdm_warning_manager.sv]
/*
 drive warning manager: detectors, mask, latch policy,
 routing, display and a wishbone slave.
 assumes detectors run on clk_i; alarm clear and
 power sense are pins, synchronised here.
*/
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "wdm_defines.svh"

// Behaviour
// - non-latch warning clears one second after cause
// - latch warning held until alarm clear
// - battery warning clears on alarm clear after encoder latch released
// - selector one picks warning; zero ORs all
// - selector two picks warning; zero ORs all
// - policy bit0 extended, bit1 general latching
// - mask bit one suppresses that warning
// - oscillation above threshold; zero threshold disables
// - power off after set ms; 0-9, 2000 disable
// - power loss sets main power off flag
// - consecutive receive errors reaching limit warn
// - accumulated receive errors reaching limit warn
// - update failures above setting warn; 0,1 disable
// - display alternates code, dot flashes with code
// - overload, regeneration warn at 85 percent
// - battery low warns, always latched
// - fan stopped one second warns
// - successive encoder link errors over limit warn
// - encoder overheat warns
// - oscillation warning code A6, selector 7
// - lifetime warning, always latched
// - deterioration warning code AC, selector 22
// - held alarm clear clears all warnings
module wdm_warning_manager #(
  parameter logic [31:0] SEC_CYCLES   = `WDM_CLEAR_DELAY_S * `WDM_CLK_HZ,
  parameter logic [31:0] FAN_CYCLES   = `WDM_FAN_STOP_S * `WDM_CLK_HZ,
  parameter logic [31:0] MS_CYCLES    = `WDM_CLK_HZ / `WDM_MS_PER_S,
  parameter logic [31:0] PHASE_CYCLES = `WDM_DISP_PHASE_MS * (`WDM_CLK_HZ / `WDM_MS_PER_S),
  parameter logic [31:0] BLINK_CYCLES = `WDM_BLINK_MS * (`WDM_CLK_HZ / `WDM_MS_PER_S),
  parameter logic [15:0] ENC_ERR_LIM  = 16'h0003
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // pins
  input  wire logic             alarm_clear_input_i,
  input  wire logic             main_power_ok_i,
  // internal detectors
  input  wire logic [7:0]       load_pct_i,
  input  wire logic [7:0]       regen_pct_i,
  input  wire logic             batt_enc_latch_i,
  input  wire logic             fan_stopped_i,
  input  wire logic             enc_err_i,
  input  wire logic             enc_ok_i,
  input  wire logic             enc_overheat_i,
  input  wire logic [15:0]      vib_level_i,
  input  wire logic             life_low_i,
  input  wire logic             deter_out_i,
  input  wire logic             rx_err_i,
  input  wire logic             rx_ok_i,
  input  wire logic             upd_fail_i,
  // outputs
  output logic                  warning_output_one_o,
  output logic                  warning_output_two_o,
  output logic                  main_power_off_flag_o,
  output logic [`WDM_NUM_WARN-1:0] warn_active_o,
  output wdm_pkg::wdm_disp_t    disp_o
);

  localparam int N = `WDM_NUM_WARN;

  // ==========================================
  // warning table, index order
  localparam logic [7:0] CODE [N] = '{`WDM_CODE_OVERLOAD, `WDM_CODE_REGEN,
    `WDM_CODE_BATTERY, `WDM_CODE_FAN, `WDM_CODE_ENC_LINK, `WDM_CODE_ENC_HEAT,
    `WDM_CODE_OSC, `WDM_CODE_LIFE, `WDM_CODE_DETER, `WDM_CODE_CONSEC,
    `WDM_CODE_TOTAL, `WDM_CODE_UPDATE, `WDM_CODE_PWR_OFF};
  localparam logic [15:0] SEL [N] = '{`WDM_SEL_OVERLOAD, `WDM_SEL_REGEN,
    `WDM_SEL_BATTERY, `WDM_SEL_FAN, `WDM_SEL_ENC_LINK, `WDM_SEL_ENC_HEAT,
    `WDM_SEL_OSC, `WDM_SEL_LIFE, `WDM_SEL_DETER, `WDM_SEL_CONSEC,
    `WDM_SEL_TOTAL, `WDM_SEL_UPDATE, `WDM_SEL_PWR_OFF};
  localparam logic [4:0] MB [N] = '{`WDM_MB_OVERLOAD, `WDM_MB_REGEN,
    `WDM_MB_BATTERY, `WDM_MB_FAN, `WDM_MB_ENC_LINK, `WDM_MB_ENC_HEAT,
    `WDM_MB_OSC, `WDM_MB_LIFE, `WDM_MB_DETER, `WDM_MB_CONSEC,
    `WDM_MB_TOTAL, `WDM_MB_UPDATE, `WDM_MB_PWR_OFF};
  localparam wdm_pkg::wdm_cls_t CLS [N] = '{wdm_pkg::WDM_CLS_GEN,
    wdm_pkg::WDM_CLS_GEN, wdm_pkg::WDM_CLS_FIXED, wdm_pkg::WDM_CLS_GEN,
    wdm_pkg::WDM_CLS_GEN, wdm_pkg::WDM_CLS_GEN, wdm_pkg::WDM_CLS_GEN,
    wdm_pkg::WDM_CLS_FIXED, wdm_pkg::WDM_CLS_GEN, wdm_pkg::WDM_CLS_EXT,
    wdm_pkg::WDM_CLS_FIXED, wdm_pkg::WDM_CLS_FIXED, wdm_pkg::WDM_CLS_EXT};

  // ==========================================
  // functions
  function automatic logic route(input logic [15:0] sel, input logic [N-1:0] act);
    logic hit;
    hit = 1'b0;
    if (sel == `WDM_SEL_OR_ALL) begin
      hit = |act;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (SEL[i] == sel) begin
          hit = act[i];
        end
      end
    end
    return hit;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [3:0] sel,
                                        input logic [31:0] dat);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // ==========================================
  // pin synchronisers
  logic [1:0] clr_sync_r;
  logic [1:0] pwr_sync_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_sync_r <= 2'h0;
      pwr_sync_r <= 2'h3;
    end else begin
      clr_sync_r <= {clr_sync_r[0], alarm_clear_input_i};
      pwr_sync_r <= {pwr_sync_r[0], main_power_ok_i};
    end
  end
  wire clr_w    = clr_sync_r[1];
  wire pwr_ok_w = pwr_sync_r[1];

  // ==========================================
  // register bus
  wdm_pkg::wdm_cfg_t cfg_r;
  logic [N-1:0]      active_r;
  logic              pwr_flag_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  wire               req_w = wb_cyc_i & wb_stb_i & ~ack_r;
  wire               wr_w  = req_w & wb_we_i;
  logic [31:0]       rd_nxt;

  always_comb begin
    unique case (wb_adr_i)
      `WDM_ADR_OUT1_SEL:   rd_nxt = {16'h0, cfg_r.out1_sel};
      `WDM_ADR_OUT2_SEL:   rd_nxt = {16'h0, cfg_r.out2_sel};
      `WDM_ADR_LATCH_POL:  rd_nxt = {16'h0, cfg_r.latch_pol};
      `WDM_ADR_OSC_THR:    rd_nxt = {16'h0, cfg_r.osc_thr};
      `WDM_ADR_MASK_A:     rd_nxt = {16'h0, cfg_r.mask_a};
      `WDM_ADR_MASK_B:     rd_nxt = {16'h0, cfg_r.mask_b};
      `WDM_ADR_PWR_TIME:   rd_nxt = {16'h0, cfg_r.pwr_time};
      `WDM_ADR_CONSEC_LIM: rd_nxt = {16'h0, cfg_r.consec_lim};
      `WDM_ADR_TOTAL_LIM:  rd_nxt = {16'h0, cfg_r.total_lim};
      `WDM_ADR_UPD_LIM:    rd_nxt = {16'h0, cfg_r.upd_lim};
      `WDM_ADR_STATUS:     rd_nxt = {{(32-N){1'b0}}, active_r};
      `WDM_ADR_NET_STATUS: rd_nxt = {31'h0, pwr_flag_r};
      default:             rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= {10{`WDM_RST_REG}};
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req_w;
      dat_r <= req_w ? rd_nxt : 32'h0;
      if (wr_w) begin
        unique case (wb_adr_i)
          `WDM_ADR_OUT1_SEL:   cfg_r.out1_sel   <= wr16(cfg_r.out1_sel, wb_sel_i, wb_dat_i);
          `WDM_ADR_OUT2_SEL:   cfg_r.out2_sel   <= wr16(cfg_r.out2_sel, wb_sel_i, wb_dat_i);
          `WDM_ADR_LATCH_POL:  cfg_r.latch_pol  <= wr16(cfg_r.latch_pol, wb_sel_i, wb_dat_i);
          `WDM_ADR_OSC_THR:    cfg_r.osc_thr    <= wr16(cfg_r.osc_thr, wb_sel_i, wb_dat_i);
          `WDM_ADR_MASK_A:     cfg_r.mask_a     <= wr16(cfg_r.mask_a, wb_sel_i, wb_dat_i);
          `WDM_ADR_MASK_B:     cfg_r.mask_b     <= wr16(cfg_r.mask_b, wb_sel_i, wb_dat_i);
          `WDM_ADR_PWR_TIME:   cfg_r.pwr_time   <= wr16(cfg_r.pwr_time, wb_sel_i, wb_dat_i);
          `WDM_ADR_CONSEC_LIM: cfg_r.consec_lim <= wr16(cfg_r.consec_lim, wb_sel_i, wb_dat_i);
          `WDM_ADR_TOTAL_LIM:  cfg_r.total_lim  <= wr16(cfg_r.total_lim, wb_sel_i, wb_dat_i);
          `WDM_ADR_UPD_LIM:    cfg_r.upd_lim    <= wr16(cfg_r.upd_lim, wb_sel_i, wb_dat_i);
          default:             cfg_r <= cfg_r;
        endcase
      end
    end
  end

  // ==========================================
  // event counters
  logic [15:0] enc_cnt_r;
  logic [15:0] consec_cnt_r;
  logic [15:0] total_cnt_r;
  logic [15:0] upd_cnt_r;
  logic [31:0] fan_cnt_r;
  logic [31:0] ms_pre_r;
  logic [15:0] off_ms_r;
  wire         ms_tick_w = (ms_pre_r == MS_CYCLES - 32'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_cnt_r    <= 16'h0;
      consec_cnt_r <= 16'h0;
      total_cnt_r  <= 16'h0;
      upd_cnt_r    <= 16'h0;
      fan_cnt_r    <= 32'h0;
      ms_pre_r     <= 32'h0;
      off_ms_r     <= 16'h0;
    end else begin
      enc_cnt_r    <= enc_err_i ? sat_inc(enc_cnt_r) : (enc_ok_i ? 16'h0000 : enc_cnt_r);
      consec_cnt_r <= rx_err_i ? sat_inc(consec_cnt_r) : (rx_ok_i ? 16'h0000 : consec_cnt_r);
      if (rx_err_i) begin
        total_cnt_r <= sat_inc(total_cnt_r);
      end else if (clr_w) begin
        total_cnt_r <= 16'h0000;
      end
      if (upd_fail_i) begin
        upd_cnt_r <= sat_inc(upd_cnt_r);
      end else if (clr_w) begin
        upd_cnt_r <= 16'h0000;
      end
      if (!fan_stopped_i) begin
        fan_cnt_r <= 32'h0;
      end else if (fan_cnt_r != FAN_CYCLES) begin
        fan_cnt_r <= fan_cnt_r + 32'h1;
      end
      if (pwr_ok_w) begin
        ms_pre_r <= 32'h0;
        off_ms_r <= 16'h0;
      end else begin
        ms_pre_r <= ms_tick_w ? 32'h0 : ms_pre_r + 32'h1;
        if (ms_tick_w) begin
          off_ms_r <= sat_inc(off_ms_r);
        end
      end
    end
  end

  // ==========================================
  // raw causes
  logic [N-1:0] cause_w;
  wire [31:0]   mask_w    = {cfg_r.mask_b, cfg_r.mask_a};
  wire          pwr_en_w  = (cfg_r.pwr_time >= `WDM_PWR_MIN_MS) &&
                            (cfg_r.pwr_time <= `WDM_PWR_MAX_MS);
  wire          pwr_off_w = pwr_en_w && (off_ms_r > cfg_r.pwr_time);
  assign cause_w[0]  = load_pct_i >= `WDM_LOAD_WARN_PCT;
  assign cause_w[1]  = regen_pct_i >= `WDM_LOAD_WARN_PCT;
  assign cause_w[2]  = batt_enc_latch_i;
  assign cause_w[3]  = fan_cnt_r == FAN_CYCLES;
  assign cause_w[4]  = enc_cnt_r > ENC_ERR_LIM;
  assign cause_w[5]  = enc_overheat_i;
  assign cause_w[6]  = (cfg_r.osc_thr != 16'h0000) && (vib_level_i > cfg_r.osc_thr);
  assign cause_w[7]  = life_low_i;
  assign cause_w[8]  = deter_out_i;
  assign cause_w[9]  = (cfg_r.consec_lim != 16'h0000) &&
                       (consec_cnt_r >= cfg_r.consec_lim);
  assign cause_w[10] = (cfg_r.total_lim != 16'h0000) &&
                       (total_cnt_r >= cfg_r.total_lim);
  assign cause_w[11] = (cfg_r.upd_lim >= `WDM_UPD_MIN_LIM) &&
                       (upd_cnt_r > cfg_r.upd_lim);
  assign cause_w[12] = pwr_off_w;

  // ==========================================
  // mask and latch policy per warning
  logic [N-1:0] det_w;
  logic [N-1:0] latch_w;
  logic [31:0]  hold_r [N];
  logic [N-1:0] active_nxt;
  for (genvar g = 0; g < N; g++) begin : g_warn
    assign det_w[g]   = cause_w[g] & ~mask_w[MB[g]];
    assign latch_w[g] = (CLS[g] == wdm_pkg::WDM_CLS_FIXED) ||
                        ((CLS[g] == wdm_pkg::WDM_CLS_EXT) && cfg_r.latch_pol[`WDM_POL_EXT_BIT]) ||
                        ((CLS[g] == wdm_pkg::WDM_CLS_GEN) &&
                         cfg_r.latch_pol[`WDM_POL_GEN_BIT]);
    // detection wins over a clear in the same cycle
    assign active_nxt[g] = det_w[g] |
                           (active_r[g] & ~clr_w &
                            (latch_w[g] | (hold_r[g] != SEC_CYCLES - 32'h1)));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        hold_r[g] <= 32'h0;
      end else if (det_w[g] || !active_r[g]) begin
        hold_r[g] <= 32'h0;
      end else if (!latch_w[g]) begin
        hold_r[g] <= hold_r[g] + 32'h1;
      end
    end
  end

  // ==========================================
  // state, outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r   <= '0;
      pwr_flag_r <= 1'b0;
    end else begin
      active_r   <= active_nxt;
      pwr_flag_r <= pwr_off_w;
    end
  end

  logic out1_r;
  logic out2_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end else begin
      out1_r <= route(cfg_r.out1_sel, active_r);
      out2_r <= route(cfg_r.out2_sel, active_r);
    end
  end

  // ==========================================
  // display alternation
  logic [31:0]        phase_cnt_r;
  logic [31:0]        blink_cnt_r;
  logic               phase_r;
  logic               blink_r;
  wdm_pkg::wdm_disp_t disp_r;
  logic [7:0]         code_w;

  always_comb begin
    code_w = 8'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (active_r[i]) begin
        code_w = CODE[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !(|active_r)) begin
      phase_cnt_r <= 32'h0;
      blink_cnt_r <= 32'h0;
      phase_r     <= 1'b0;
      blink_r     <= 1'b0;
      disp_r      <= '0;
    end else begin
      phase_cnt_r <= (phase_cnt_r == PHASE_CYCLES - 32'h1) ? 32'h0 : phase_cnt_r + 32'h1;
      blink_cnt_r <= (blink_cnt_r == BLINK_CYCLES - 32'h1) ? 32'h0 : blink_cnt_r + 32'h1;
      if (phase_cnt_r == PHASE_CYCLES - 32'h1) begin
        phase_r <= ~phase_r;
      end
      if (blink_cnt_r == BLINK_CYCLES - 32'h1) begin
        blink_r <= ~blink_r;
      end
      disp_r.show_code <= phase_r;
      disp_r.code      <= code_w;
      disp_r.dot       <= phase_r & blink_r;
    end
  end

  assign wb_dat_o              = dat_r;
  assign wb_ack_o              = ack_r;
  assign warning_output_one_o  = out1_r;
  assign warning_output_two_o  = out2_r;
  assign main_power_off_flag_o = pwr_flag_r;
  assign warn_active_o         = active_r;
  assign disp_o                = disp_r;

endmodule

// [wdm_defines.svh]
/*
 drive warning manager: shared constants.
 assumes inclusion by bare name.
*/
`ifndef WDM_DEFINES_SVH
`define WDM_DEFINES_SVH

// ==========================================
// clock and times
`define WDM_CLK_HZ          20000000
`define WDM_CLEAR_DELAY_S   1
`define WDM_FAN_STOP_S      1
`define WDM_MS_PER_S        1000
`define WDM_DISP_PHASE_MS   500
`define WDM_BLINK_MS        125

// ==========================================
// register byte offsets
`define WDM_ADR_OUT1_SEL    8'h00
`define WDM_ADR_OUT2_SEL    8'h04
`define WDM_ADR_LATCH_POL   8'h08
`define WDM_ADR_OSC_THR     8'h0C
`define WDM_ADR_MASK_A      8'h10
`define WDM_ADR_MASK_B      8'h14
`define WDM_ADR_PWR_TIME    8'h18
`define WDM_ADR_CONSEC_LIM  8'h1C
`define WDM_ADR_TOTAL_LIM   8'h20
`define WDM_ADR_UPD_LIM     8'h24
`define WDM_ADR_STATUS      8'h28
`define WDM_ADR_NET_STATUS  8'h2C

// ==========================================
// reset values
`define WDM_RST_REG         16'h0000

// ==========================================
// fields and limits
`define WDM_POL_EXT_BIT     0
`define WDM_POL_GEN_BIT     1
`define WDM_PWR_MIN_MS      16'h000A
`define WDM_PWR_MAX_MS      16'h07CF
`define WDM_UPD_MIN_LIM     16'h0002
`define WDM_LOAD_WARN_PCT   8'h55
`define WDM_NET_PWR_OFF_BIT 0
`define WDM_MASK_B_BASE     16
`define WDM_NUM_WARN        13

// ==========================================
// warning codes
`define WDM_CODE_OVERLOAD   8'hA0
`define WDM_CODE_REGEN      8'hA1
`define WDM_CODE_BATTERY    8'hA2
`define WDM_CODE_FAN        8'hA3
`define WDM_CODE_ENC_LINK   8'hA4
`define WDM_CODE_ENC_HEAT   8'hA5
`define WDM_CODE_OSC        8'hA6
`define WDM_CODE_LIFE       8'hA7
`define WDM_CODE_DETER      8'hAC
`define WDM_CODE_CONSEC     8'hC0
`define WDM_CODE_TOTAL      8'hC1
`define WDM_CODE_UPDATE     8'hC2
`define WDM_CODE_PWR_OFF    8'hC3

// ==========================================
// output selector values
`define WDM_SEL_OR_ALL      16'h0000
`define WDM_SEL_OVERLOAD    16'h0001
`define WDM_SEL_REGEN       16'h0002
`define WDM_SEL_BATTERY     16'h0003
`define WDM_SEL_FAN         16'h0004
`define WDM_SEL_ENC_LINK    16'h0005
`define WDM_SEL_ENC_HEAT    16'h0006
`define WDM_SEL_OSC         16'h0007
`define WDM_SEL_LIFE        16'h0008
`define WDM_SEL_DETER       16'h0016
`define WDM_SEL_CONSEC      16'h000B
`define WDM_SEL_TOTAL       16'h000C
`define WDM_SEL_UPDATE      16'h000D
`define WDM_SEL_PWR_OFF     16'h000E

// ==========================================
// mask bit positions in {mask_b, mask_a}
`define WDM_MB_OVERLOAD     5'd7
`define WDM_MB_REGEN        5'd5
`define WDM_MB_BATTERY      5'd0
`define WDM_MB_FAN          5'd6
`define WDM_MB_ENC_LINK     5'd4
`define WDM_MB_ENC_HEAT     5'd3
`define WDM_MB_OSC          5'd13
`define WDM_MB_LIFE         5'd2
`define WDM_MB_DETER        5'd23
`define WDM_MB_CONSEC       5'd9
`define WDM_MB_TOTAL        5'd10
`define WDM_MB_UPDATE       5'd11
`define WDM_MB_PWR_OFF      5'd12

`endif

// [wdm_pkg.sv]
/*
 drive warning manager: shared types.
 assumes wdm_defines.svh is on the include path.
*/
package wdm_pkg;
`include "wdm_defines.svh"

  // latch class of a warning
  typedef enum logic [1:0] {
    WDM_CLS_GEN   = 2'h0,
    WDM_CLS_EXT   = 2'h1,
    WDM_CLS_FIXED = 2'h2
  } wdm_cls_t;

  // software settings
  typedef struct packed {
    logic [15:0] out1_sel;
    logic [15:0] out2_sel;
    logic [15:0] latch_pol;
    logic [15:0] osc_thr;
    logic [15:0] mask_a;
    logic [15:0] mask_b;
    logic [15:0] pwr_time;
    logic [15:0] consec_lim;
    logic [15:0] total_lim;
    logic [15:0] upd_lim;
  } wdm_cfg_t;

  // front display drive
  typedef struct packed {
    logic       show_code;
    logic [7:0] code;
    logic       dot;
  } wdm_disp_t;

endpackage

// [wdm_warning_properties.sv]
/*
 checker on the warning manager ports.
 assumes the bind below.
*/
`timescale 1ns/100ps
`include "wdm_defines.svh"
module wdm_warning_properties (
  // clock and reset
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  // bus
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [7:0]               wb_adr_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  // warnings
  input wire logic                     main_power_ok_i,
  input wire logic [7:0]               load_pct_i,
  input wire logic                     warning_output_one_o,
  input wire logic                     warning_output_two_o,
  input wire logic                     main_power_off_flag_o,
  input wire logic [`WDM_NUM_WARN-1:0] warn_active_o,
  input wire wdm_pkg::wdm_disp_t       disp_o
);
  // ==========================================
  // copy of mask word a
  logic [15:0] mask_a_r;
  wire         mask_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o
                         & (wb_adr_i == `WDM_ADR_MASK_A);
  always_ff @(posedge clk_i) begin
    if (rst_i) mask_a_r <= 16'h0000;
    else if (mask_wr) mask_a_r <= wb_dat_i[15:0];
  end
  // ==========================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_request;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence power_gone;
    $fell(main_power_ok_i) ##1 !main_power_ok_i [*4];
  endsequence
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_next_a: assert property (bus_request |=> wb_ack_o)
    else $error("no ack");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  outputs_idle_a: assert property (
    warn_active_o == '0 |=> !warning_output_one_o && !warning_output_two_o)
    else $error("output without warning");
  flag_early_a: assert property (power_gone |-> !main_power_off_flag_o)
    else $error("flag too early");
  flag_clear_a: assert property (main_power_ok_i [*5] |-> !main_power_off_flag_o)
    else $error("flag with power");
  code_shown_a: assert property (
    disp_o.show_code |-> (|warn_active_o) || (|$past(warn_active_o)))
    else $error("code without warning");
  dot_code_a: assert property (disp_o.dot |-> disp_o.show_code)
    else $error("dot outside code");
  overload_set_a: assert property (
    load_pct_i >= `WDM_LOAD_WARN_PCT && !mask_a_r[`WDM_MB_OVERLOAD] |=> warn_active_o[0])
    else $error("overload missing");
endmodule
bind wdm_warning_manager wdm_warning_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .main_power_ok_i(main_power_ok_i), .load_pct_i(load_pct_i),
  .warning_output_one_o(warning_output_one_o), .warning_output_two_o(warning_output_two_o),
  .main_power_off_flag_o(main_power_off_flag_o), .warn_active_o(warn_active_o),
  .disp_o(disp_o));

// [wdm_host_model.sv]
/*
 host model: classic wishbone master.
 assumes one clock; bench calls xfer per access.
*/
`timescale 1ns/100ps
module wdm_host_model (
  // clock
  input  wire logic   clk_i,
  // wishbone master
  output logic        wb_cyc_o,
  output logic        wb_stb_o,
  output logic        wb_we_o,
  output logic [7:0]  wb_adr_o,
  output logic [3:0]  wb_sel_o,
  output logic [31:0] wb_dat_o,
  input  wire logic   wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'hFF;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // ==========================================
  // one held cycle per call
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= dat;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~dat;
  endtask
endmodule

// [tb_top.sv]
/*
 tb_top: self-checking warning manager bench.
 assumes host model and checker are compiled.
*/
`timescale 1ns/100ps
`include "wdm_defines.svh"
module tb_top;
  // ==========================================
  // signals
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc, stb, we, ack, o1, o2, pf;
  logic               aclr = 1'b0;
  logic               pwr = 1'b1;
  logic [7:0]         adr;
  logic [7:0]         lo = 8'h00;
  logic [7:0]         lv = 8'h00;
  logic [4:0]         ev = 5'h00;
  logic [3:0]         sel;
  logic [31:0]        dw, dr, e, r;
  wdm_pkg::wdm_disp_t disp;
  integer             seed = 32'h07C4;
  int                 n_fail = 0;
  int                 n_tests = 0;
  int                 ncyc = 0;
  logic [31:0]        exp_q[$];
  logic [15:0]        sel_t[8] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004,
                                   16'h0006, 16'h0007, 16'h0008, 16'h0016};
  logic [7:0]         code_t[8] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA5, 8'hA6, 8'hA7, 8'hAC};
  always #25 clk_i = ~clk_i;
  // ==========================================
  // instances
  wdm_host_model u_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_ack_i(ack));
  wdm_warning_manager #(.SEC_CYCLES(32'h14), .FAN_CYCLES(32'hA), .MS_CYCLES(32'h4),
    .PHASE_CYCLES(32'h8), .BLINK_CYCLES(32'h2)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .alarm_clear_input_i(aclr),
    .main_power_ok_i(pwr), .load_pct_i(lv[0] ? 8'h55 : lo),
    .regen_pct_i(lv[1] ? 8'h55 : lo), .batt_enc_latch_i(lv[2]), .fan_stopped_i(lv[3]),
    .enc_err_i(ev[0]), .enc_ok_i(ev[3]), .enc_overheat_i(lv[4]),
    .vib_level_i(lv[5] ? 16'h0065 : 16'h0064), .life_low_i(lv[6]), .deter_out_i(lv[7]),
    .rx_err_i(ev[1]), .rx_ok_i(ev[4]), .upd_fail_i(ev[2]), .warning_output_one_o(o1),
    .warning_output_two_o(o2), .main_power_off_flag_o(pf), .warn_active_o(), .disp_o(disp));
  // ==========================================
  // tasks
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("BAD t=%0t read %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_out(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("BAD t=%0t output %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    exp_q.push_back(d);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic st(input logic [31:0] d);
    rd(`WDM_ADR_STATUS, d);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic clr();
    @(posedge clk_i);
    aclr <= 1'b1;
    w(6);
    aclr <= 1'b0;
    w(4);
  endtask
  task automatic hit(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev <= 5'h01 << k;
      @(posedge clk_i);
      ev <= 5'h00;
    end
    w(2);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // read monitor and timeout
  always @(posedge clk_i) begin
    ncyc++;
    if (ack === 1'b1 && we === 1'b0) begin
      e = exp_q.pop_front();
      chk_rd(dr, e);
    end
    if (ncyc == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    w(5);
    rst_i <= 1'b0;
    for (int k = 0; k < 13; k++) begin
      r = $random(seed);
      rd(8'(k * 4), 32'h0);
      wr(8'(k * 4), r);
      rd(8'(k * 4), k < 10 ? {16'h0, r[15:0]} : 32'h0);
      wr(8'(k * 4), 32'h0);
    end
    $display("test registers done");
    wr(`WDM_ADR_OSC_THR, 32'h64);
    for (int i = 0; i < 8; i++) begin
      wr(`WDM_ADR_LATCH_POL, i[0] ? 32'h2 : 32'h0);
      wr(`WDM_ADR_OUT1_SEL, i[0] ? {16'h0, sel_t[i]} : 32'h0);
      wr(`WDM_ADR_OUT2_SEL, {16'h0, i[0] ? sel_t[(i + 1) % 8] : sel_t[i]});
      lo <= 8'($unsigned($random(seed)) % 85);
      lv <= 8'h01 << i;
      w(16);
      st(32'h1 << (i < 4 ? i : i + 1));
      chk_out({7'h0, o1}, 8'h01);
      chk_out({7'h0, o2}, i[0] ? 8'h00 : 8'h01);
      for (int t = 0; t < 20 && disp.show_code !== 1'b1; t++) @(posedge clk_i);
      chk_out(disp.code, code_t[i]);
      lv <= 8'h00;
      w(30);
      st((i[0] || i == 2 || i == 6) ? 32'h1 << (i < 4 ? i : i + 1) : 32'h0);
      clr();
      st(32'h0);
    end
    $display("test warning table done");
    wr(`WDM_ADR_LATCH_POL, 32'h0);
    lv <= 8'h01;
    w(4);
    lv <= 8'h00;
    w(12);
    lv <= 8'h01;
    @(posedge clk_i);
    lv <= 8'h00;
    w(14);
    st(32'h1);
    w(25);
    st(32'h0);
    wr(`WDM_ADR_MASK_A, 32'h80);
    wr(`WDM_ADR_MASK_B, 32'h80);
    wr(`WDM_ADR_OSC_THR, 32'h0);
    lv <= 8'hA1;
    w(16);
    st(32'h0);
    lv <= 8'h00;
    wr(`WDM_ADR_MASK_A, 32'h0);
    wr(`WDM_ADR_MASK_B, 32'h0);
    $display("test mask done");
    wr(`WDM_ADR_CONSEC_LIM, 32'h3);
    wr(`WDM_ADR_UPD_LIM, 32'h2);
    wr(`WDM_ADR_LATCH_POL, 32'h1);
    hit(1, 2);
    hit(2, 2);
    hit(0, 3);
    st(32'h0);
    hit(1, 1);
    hit(2, 1);
    hit(0, 1);
    st(32'h0A10);
    hit(3, 1);
    hit(4, 1);
    w(30);
    st(32'h0A00);
    clr();
    wr(`WDM_ADR_CONSEC_LIM, 32'h0);
    wr(`WDM_ADR_TOTAL_LIM, 32'h4);
    hit(1, 3);
    st(32'h0);
    hit(1, 1);
    st(32'h0400);
    clr();
    st(32'h0);
    $display("test error counts done");
    wr(`WDM_ADR_LATCH_POL, 32'h0);
    wr(`WDM_ADR_PWR_TIME, 32'hA);
    pwr <= 1'b0;
    w(8);
    chk_out({7'h0, pf}, 8'h00);
    st(32'h0);
    w(60);
    st(32'h1000);
    chk_out({7'h0, pf}, 8'h01);
    pwr <= 1'b1;
    w(8);
    chk_out({7'h0, pf}, 8'h00);
    w(30);
    st(32'h0);
    wr(`WDM_ADR_PWR_TIME, 32'h7D0);
    pwr <= 1'b0;
    w(80);
    st(32'h0);
    chk_out({7'h0, pf}, 8'h00);
    pwr <= 1'b1;
    $display("test power done");
    w(10);
    if (exp_q.size() != 0) n_fail++;
    report_and_stop();
  end
endmodule
